// [testbench/prog_mem_model.sv]
// Purpose: program memory and interrupt source beside the sequencer
// Assumes: word follows the fetch address combinationally
// Notes: unwritten words read as no-op
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
    input wire logic [10:0] addr,
    input wire logic irq_set,
    output logic [15:0] word,
    output logic irq
);
    // skip, call and return, low byte jump, then a loop on itself
    always_comb begin
        case (addr)
            11'h000: word = 16'h1F00; // acc cleared
            11'h001: word = 16'h6000; // skip on zero, taken
            11'h002: word = 16'h27FF; // must never run
            11'h003: word = 16'h3010; // call
            11'h004: word = 16'h7000; // low byte jump, also the vector
            11'h005: word = 16'h2005; // jump to itself
            11'h010: word = 16'h1005; // add five
            11'h011: word = 16'h4000; // return
            default: word = 16'h0000;
        endcase
    end
    assign irq = irq_set; // request level from the bench
endmodule
`default_nettype wire

// [testbench/seq_checker.sv]
// Purpose: port assertions for the sequencer
// Assumes: run bit stays set
// Notes: vector match excuses dummy steps at interrupt entry
`timescale 1ns/1ps
`default_nettype none
module seq_checker #(parameter int PC_W = 11, parameter logic [11:0] INT_VECTOR = 12'h004) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] phase_num,
    input wire logic [PC_W-1:0] fetch_addr,
    input wire logic dummy_cycle,
    input wire logic int_ack,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    localparam logic [PC_W-1:0] VEC = INT_VECTOR[PC_W-1:0]; // entry address in counter width
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_PHASE: assert property (phase_num != 2'd0 |=> phase_num == $past(phase_num) + 2'd1) else $error("phase");
    AST_PC_HOLD: assert property (phase_num != 2'd3 |=> $stable(fetch_addr)) else $error("pc moved");
    AST_DUM_HOLD: assert property (phase_num != 2'd3 |=> $stable(dummy_cycle)) else $error("dummy moved");
    AST_DUM_STEP: assert property (phase_num == 2'd3 && dummy_cycle |=> fetch_addr == $past(fetch_addr)
        + 1'b1 || fetch_addr == VEC) else $error("dummy step");
    AST_DUM_ONE: assert property (phase_num == 2'd3 && dummy_cycle |=> !dummy_cycle || fetch_addr == VEC)
        else $error("dummy twice");
    AST_ACK_PULSE: assert property (int_ack |=> !int_ack) else $error("ack width");
    AST_ACK_VEC: assert property ($rose(int_ack) |-> fetch_addr == VEC && dummy_cycle) else $error("vector");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid");
    AST_AR_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
endmodule
bind cpu_program_sequencer seq_checker #(.PC_W(PC_W), .INT_VECTOR(INT_VECTOR)) seq_checker_inst (.clk, .rst,
    .phase_num, .fetch_addr, .dummy_cycle, .int_ack, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_bvalid, .s_axi_bready);
`default_nettype wire

// [testbench/tb.sv]
// Purpose: directed bench for the sequencer
// Assumes: default counter width, run bit left set
// Notes: fetch trace is sampled once per instruction cycle
`timescale 1ns/1ps
`default_nettype none
module tb;
    import seq_pkg::*;
    logic clk = 0, rst = 1, irq_set = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, int_req, int_ack, dummy_cycle;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [1:0] bresp, rresp, rr, phase_num;
    logic [10:0] fetch_addr;
    logic [15:0] word;
    logic [10:0] fa_q[$];
    logic dm_q[$];
    logic [10:0] fa_exp [12] = '{11'h000, 11'h001, 11'h002, 11'h003, 11'h004, 11'h010, 11'h011, 11'h012,
        11'h004, 11'h005, 11'h005, 11'h006};
    logic [11:0] dm_exp = 12'h528; // one bit a cycle, first cycle in bit 0
    int num_errors = 0, cmp_count = 0;
    cpu_program_sequencer cpu_program_sequencer_inst (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .instr_data(word), .int_req(int_req), .fetch_addr(fetch_addr), .phase_num(phase_num),
        .int_ack(int_ack), .dummy_cycle(dummy_cycle));
    prog_mem_model prog_mem_model_inst (.addr(fetch_addr), .irq_set(irq_set), .word(word), .irq(int_req));
    initial forever #10 clk = ~clk;
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // write: address and data together, response waited for
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", 32'(bresp), 32'(er));
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask
    // one trace entry per instruction cycle
    always @(posedge clk) begin
        if (!rst && phase_num == 2'd1) begin
            fa_q.push_back(fetch_addr);
            dm_q.push_back(dummy_cycle);
        end
    end
    // hang guard, about a hundred cycles are expected
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (60) @(posedge clk);
        for (int i = 0; i < 12; i++) begin
            chk("fetch_addr", 32'(fa_q[i]), 32'(fa_exp[i]));
            chk("dummy", 32'(dm_q[i]), 32'(dm_exp[i]));
        end
        axr(REG_STATUS_OFF, rd, rr);
        chk("acc", 32'(rd[STAT_ACC_LSB +: 8]), 32'h0000_0005);
        axr(8'h40, rd, rr);
        chk("rresp", 32'(rr), 32'(RESP_SLVERR));
        chk("rdata", rd, 32'h0000_0000);
        axw(REG_STATUS_OFF, 32'h0000_0000, RESP_SLVERR);
        axw(REG_CTRL_OFF, 32'h0000_0003, RESP_OKAY);
        irq_set <= 1'b1;
        for (int i = 0; i < 60 && int_ack !== 1'b1; i++) @(posedge clk);
        chk("int_ack", 32'(int_ack), 32'h0000_0001);
        chk("vector", 32'(fetch_addr), 32'h0000_0004);
        irq_set <= 1'b0;
        tally_and_finish();
    end
endmodule
`default_nettype wire

// [verilog/cpu_program_sequencer.sv]
// Purpose: four-phase program sequencer with return stack, accumulator alu and AXI4-Lite access
// Assumes: program memory answers within one instruction cycle; int_req comes from same-clock logic
// Notes: one instruction cycle is four clocks; jumps, calls, returns, low byte writes and taken skips cost a second, dummy cycle
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cpu_program_sequencer #(
    parameter int PC_W = 11, // 11 for the small memory, 12 for the large
    parameter int STACK_DEPTH = 8,
    parameter logic [11:0] INT_VECTOR = 12'h004 // plain default entry address
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] instr_data,
    input wire logic int_req,
    output logic [PC_W-1:0] fetch_addr,
    output logic [1:0] phase_num,
    output logic int_ack,
    output logic dummy_cycle
);
    import seq_pkg::*;
    localparam int SP_W = $clog2(STACK_DEPTH);

    // refuse counter widths and stack depths the logic cannot serve
    if (PC_W != 11 && PC_W != 12) begin : g_bad_pc_width
        $error("PC_W must be 11 or 12");
    end
    if (STACK_DEPTH != 8) begin : g_bad_depth
        $error("STACK_DEPTH must be 8");
    end

    // maps a byte address onto a register selector, shared by read and write
    function automatic reg_sel_t decode_reg(input logic [7:0] addr);
        unique case (addr)
            REG_CTRL_OFF: decode_reg = SEL_CTRL;
            REG_LOB_OFF: decode_reg = SEL_LOB;
            REG_STATUS_OFF: decode_reg = SEL_STATUS;
            REG_INSTR_OFF: decode_reg = SEL_INSTR;
            default: decode_reg = SEL_NONE;
        endcase
    endfunction

    // bus state
    logic aw_have_r, aw_have_nxt; // write address held
    logic [7:0] aw_addr_r, aw_addr_nxt;
    logic w_have_r, w_have_nxt; // write data held
    logic [31:0] w_data_r, w_data_nxt;
    logic w_lane0_r, w_lane0_nxt; // low byte lane enabled
    logic awready_r, awready_nxt, wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wr_fire; // write performed this cycle
    reg_sel_t wr_sel, rd_sel;

    // core state
    phase_t phase_r, phase_nxt;
    logic [PC_W-1:0] pc_r, pc_nxt; // address being fetched, stepped or loaded at each boundary
    logic [15:0] ir_r, ir_nxt; // instruction under execution
    logic dummy_r, dummy_nxt;
    logic [7:0] acc_r, acc_nxt;
    logic c_r, c_nxt, z_r, z_nxt, ac_r, ac_nxt;
    logic [SP_W-1:0] sp_r, sp_nxt; // next free slot
    logic [SP_W:0] depth_r, depth_nxt; // entries held, saturates at STACK_DEPTH
    logic [PC_W-1:0] stack_r [STACK_DEPTH];
    logic [PC_W-1:0] stack_nxt [STACK_DEPTH];
    logic run_r, run_nxt, gie_r, gie_nxt;
    logic pend_r, pend_nxt; // latched interrupt request
    logic ack_r, ack_nxt;
    logic lob_pend_r, lob_pend_nxt; // bus write to low byte awaiting a boundary
    logic [7:0] lob_val_r, lob_val_nxt;

    // decode of the executing instruction
    logic [3:0] cls;
    logic boundary, stack_full, plain, take_int, take_bus_lob;
    logic [7:0] alu_y;
    logic alu_c, alu_ac, alu_z, alu_zu;
    logic [SP_W-1:0] sp_dec;
    logic [7:0] step;

    seq_alu u_alu (
        .op(ir_r[ALUOP_MSB:ALUOP_LSB]),
        .a(acc_r),
        .b(ir_r[7:0]),
        .cin(c_r),
        .acin(ac_r),
        .y(alu_y),
        .cout(alu_c),
        .acout(alu_ac),
        .zero(alu_z),
        .z_upd(alu_zu)
    );

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign fetch_addr = pc_r;
    assign phase_num = phase_r;
    assign int_ack = ack_r;
    assign dummy_cycle = dummy_r;

    assign wr_fire = aw_have_r & w_have_r & ~bvalid_r;
    assign wr_sel = decode_reg(aw_addr_r);
    assign rd_sel = decode_reg(s_axi_araddr);

    // bus slave: address and data taken in either order, response once both held
    always_comb begin
        aw_have_nxt = aw_have_r;
        aw_addr_nxt = aw_addr_r;
        w_have_nxt = w_have_r;
        w_data_nxt = w_data_r;
        w_lane0_nxt = w_lane0_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (s_axi_awvalid && awready_r) begin
            aw_have_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r) begin
            w_have_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_lane0_nxt = s_axi_wstrb[0];
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (wr_fire) begin
            // read-only and unmapped words refuse writes with an error
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = (wr_sel == SEL_CTRL || wr_sel == SEL_LOB) ? RESP_OKAY : RESP_SLVERR;
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            unique case (rd_sel)
                SEL_CTRL: begin
                    rdata_nxt[CTRL_RUN_BIT] = run_r;
                    rdata_nxt[CTRL_GIE_BIT] = gie_r;
                end
                SEL_LOB: rdata_nxt[7:0] = pc_r[7:0];
                SEL_STATUS: begin
                    // stack pointer and stack contents stay hidden
                    rdata_nxt[STAT_PC_LSB +: PC_W] = pc_r;
                    rdata_nxt[STAT_ACC_LSB +: 8] = acc_r;
                    rdata_nxt[STAT_C_BIT] = c_r;
                    rdata_nxt[STAT_Z_BIT] = z_r;
                    rdata_nxt[STAT_AC_BIT] = ac_r;
                    rdata_nxt[STAT_PEND_BIT] = pend_r;
                    rdata_nxt[STAT_DUMMY_BIT] = dummy_r;
                end
                SEL_INSTR: rdata_nxt[15:0] = ir_r;
                SEL_NONE: rresp_nxt = RESP_SLVERR;
            endcase
        end
        awready_nxt = ~aw_have_nxt & ~bvalid_nxt;
        wready_nxt = ~w_have_nxt & ~bvalid_nxt;
        arready_nxt = ~rvalid_nxt;
    end

    // bus registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_have_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_lane0_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else begin
            aw_have_r <= aw_have_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_have_r <= w_have_nxt;
            w_data_r <= w_data_nxt;
            w_lane0_r <= w_lane0_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign cls = ir_r[CLS_MSB:CLS_LSB];
    assign boundary = run_r && (phase_r == PH_WRITE);
    assign stack_full = (depth_r == (SP_W + 1)'(STACK_DEPTH));
    assign plain = !(cls inside {CLS_JMP, CLS_CALL, CLS_SUBRET, CLS_INTRET, CLS_SKIP, CLS_LOB_WR});
    assign take_int = plain && pend_r && gie_r && !stack_full;
    assign take_bus_lob = plain && !take_int && lob_pend_r;
    assign sp_dec = sp_r - 1'b1;
    assign step = (ir_r[SKC_MSB:SKC_LSB] == SK_INC_Z) ? acc_r + 8'h01 : acc_r - 8'h01;

    // sequencer: instruction effects commit at the edge that opens the fetch phase; bus writes and requests at any edge
    always_comb begin
        phase_nxt = phase_r;
        pc_nxt = pc_r;
        ir_nxt = ir_r;
        dummy_nxt = dummy_r;
        acc_nxt = acc_r;
        c_nxt = c_r;
        z_nxt = z_r;
        ac_nxt = ac_r;
        sp_nxt = sp_r;
        depth_nxt = depth_r;
        stack_nxt = stack_r;
        run_nxt = run_r;
        gie_nxt = gie_r;
        ack_nxt = 1'b0;
        lob_pend_nxt = lob_pend_r;
        lob_val_nxt = lob_val_r;
        if (run_r) begin
            unique case (phase_r)
                PH_FETCH: phase_nxt = PH_DECODE;
                PH_DECODE: phase_nxt = PH_EXEC;
                PH_EXEC: phase_nxt = PH_WRITE;
                PH_WRITE: phase_nxt = PH_FETCH;
            endcase
        end
        if (boundary) begin
            // sequential default: step the counter and keep the prefetched word
            pc_nxt = pc_r + 1'b1;
            ir_nxt = instr_data;
            dummy_nxt = 1'b0;
            unique case (cls)
                CLS_ALU: begin
                    acc_nxt = alu_y;
                    c_nxt = alu_c;
                    ac_nxt = alu_ac;
                    if (alu_zu) begin
                        z_nxt = alu_z;
                    end
                end
                CLS_JMP: pc_nxt = ir_r[PC_W-1:0];
                CLS_CALL: begin
                    // a full stack does not stop the call; the slot wraps over the oldest
                    stack_nxt[sp_r] = pc_r;
                    sp_nxt = sp_r + 1'b1;
                    if (!stack_full) begin
                        depth_nxt = depth_r + 1'b1;
                    end
                    pc_nxt = ir_r[PC_W-1:0];
                end
                CLS_SUBRET, CLS_INTRET: begin
                    pc_nxt = stack_r[sp_dec];
                    sp_nxt = sp_dec;
                    if (depth_r != '0) begin
                        depth_nxt = depth_r - 1'b1;
                    end
                    if (cls == CLS_INTRET) begin
                        gie_nxt = 1'b1;
                    end
                end
                CLS_SKIP: begin
                    if (ir_r[SKC_MSB:SKC_LSB] == SK_INC_Z || ir_r[SKC_MSB:SKC_LSB] == SK_DEC_Z) begin
                        acc_nxt = step;
                    end
                end
                CLS_LOB_WR: pc_nxt = {pc_r[PC_W-1:PAGE_BITS], acc_r};
                CLS_LOB_RD: acc_nxt = pc_r[7:0];
                default: begin
                end
            endcase
            if (!plain) begin
                // the prefetched word is dropped and a dummy cycle fetches the right one, unless a skip is not taken
                ir_nxt = INSTR_NOP;
                dummy_nxt = 1'b1;
                if (cls == CLS_SKIP) begin
                    unique case (ir_r[SKC_MSB:SKC_LSB])
                        SK_ZERO: dummy_nxt = (acc_r == 8'h00);
                        SK_NZERO: dummy_nxt = (acc_r != 8'h00);
                        SK_INC_Z, SK_DEC_Z: dummy_nxt = (step == 8'h00);
                    endcase
                    ir_nxt = dummy_nxt ? INSTR_NOP : instr_data;
                end
            end
            if (take_int) begin
                // the prefetched word was not run, so its address is the return point
                stack_nxt[sp_r] = pc_r;
                sp_nxt = sp_r + 1'b1;
                depth_nxt = depth_r + 1'b1;
                pc_nxt = INT_VECTOR[PC_W-1:0];
                ir_nxt = INSTR_NOP;
                dummy_nxt = 1'b1;
                gie_nxt = 1'b0;
                ack_nxt = 1'b1;
            end
            if (take_bus_lob) begin
                pc_nxt = {pc_r[PC_W-1:PAGE_BITS], lob_val_r};
                ir_nxt = INSTR_NOP;
                dummy_nxt = 1'b1;
                lob_pend_nxt = 1'b0;
            end
        end
        if (wr_fire && w_lane0_r) begin
            if (wr_sel == SEL_CTRL) begin
                run_nxt = w_data_r[CTRL_RUN_BIT];
                gie_nxt = w_data_r[CTRL_GIE_BIT];
            end
            if (wr_sel == SEL_LOB) begin
                lob_pend_nxt = 1'b1; // a new write outranks the clear
                lob_val_nxt = w_data_r[7:0];
            end
        end
        // a request in the acknowledge cycle is kept, the set wins
        pend_nxt = (pend_r & ~take_int & boundary) | (pend_r & ~boundary) | int_req;
    end

    // sequencer registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_r <= PH_FETCH;
            pc_r <= '0;
            ir_r <= INSTR_NOP;
            dummy_r <= 1'b0;
            acc_r <= ACC_RST;
            c_r <= 1'b0;
            z_r <= 1'b0;
            ac_r <= 1'b0;
            sp_r <= '0;
            depth_r <= '0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_r[i] <= '0;
            end
            run_r <= CTRL_RUN_RST;
            gie_r <= CTRL_GIE_RST;
            pend_r <= 1'b0;
            ack_r <= 1'b0;
            lob_pend_r <= 1'b0;
            lob_val_r <= 8'h00;
        end else begin
            phase_r <= phase_nxt;
            pc_r <= pc_nxt;
            ir_r <= ir_nxt;
            dummy_r <= dummy_nxt;
            acc_r <= acc_nxt;
            c_r <= c_nxt;
            z_r <= z_nxt;
            ac_r <= ac_nxt;
            sp_r <= sp_nxt;
            depth_r <= depth_nxt;
            stack_r <= stack_nxt;
            run_r <= run_nxt;
            gie_r <= gie_nxt;
            pend_r <= pend_nxt;
            ack_r <= ack_nxt;
            lob_pend_r <= lob_pend_nxt;
            lob_val_r <= lob_val_nxt;
        end
    end
endmodule
`default_nettype wire

// [verilog/seq_alu.sv]
// Purpose: 8-bit accumulator alu of the sequencer core
// Assumes: carry flag set means no borrow on subtract
// Notes: purely combinational, flags are committed by the caller
`timescale 1ns/1ps
`default_nettype none
module seq_alu (
    input wire logic [3:0] op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    input wire logic acin,
    output logic [7:0] y,
    output logic cout,
    output logic acout,
    output logic zero,
    output logic z_upd
);
    import seq_pkg::*;
    logic [8:0] sum9; // full adder result with carry out
    logic [4:0] nib5; // low nibble sum for auxiliary carry
    logic [7:0] bb; // b or its complement for subtract
    logic ci; // adder carry in
    logic [8:0] adj9; // decimal adjust result

    // one adder serves add, add with carry, subtract and subtract with borrow
    always_comb begin
        bb = (op == ALU_SUB || op == ALU_SBC) ? ~b : b;
        ci = (op == ALU_SUB) ? 1'b1 : ((op == ALU_ADC || op == ALU_SBC) ? cin : 1'b0);
        sum9 = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
        nib5 = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
        adj9 = {1'b0, a};
        if (a[3:0] > 4'h9 || acin) begin
            adj9 = adj9 + 9'h006;
        end
        if (adj9[7:4] > 4'h9 || cin || adj9[8]) begin
            adj9 = adj9 + 9'h060;
        end
        y = a;
        cout = cin;
        acout = acin;
        z_upd = 1'b1;
        unique case (op)
            ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
                y = sum9[7:0];
                cout = sum9[8];
                acout = nib5[4];
            end
            ALU_DAA: begin
                // decimal adjust keeps a carry that was already set
                y = adj9[7:0];
                cout = adj9[8] | cin;
                z_upd = 1'b0;
            end
            ALU_AND: y = a & b;
            ALU_OR: y = a | b;
            ALU_XOR: y = a ^ b;
            ALU_CPL: y = ~a;
            ALU_RR: begin
                y = {a[0], a[7:1]};
                z_upd = 1'b0;
            end
            ALU_RRC: begin
                y = {cin, a[7:1]};
                cout = a[0];
                z_upd = 1'b0;
            end
            ALU_RL: begin
                y = {a[6:0], a[7]};
                z_upd = 1'b0;
            end
            ALU_RLC: begin
                y = {a[6:0], cin};
                cout = a[7];
                z_upd = 1'b0;
            end
            ALU_INC: y = a + 8'h01;
            ALU_DEC: y = a - 8'h01;
            ALU_MOV: begin
                y = b;
                z_upd = 1'b0;
            end
        endcase
        zero = (y == 8'h00);
    end
endmodule
`default_nettype wire

// [verilog/seq_pkg.sv]
// Purpose: shared constants and types for the program sequencer core
// Assumes: 32-bit AXI4-Lite register bus, 16-bit program words
// Notes: instruction field layout and class codes are local to this core
`default_nettype none
package seq_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL_OFF = 8'h00;
    localparam logic [7:0] REG_LOB_OFF = 8'h04;
    localparam logic [7:0] REG_STATUS_OFF = 8'h08;
    localparam logic [7:0] REG_INSTR_OFF = 8'h0C;
    // control register fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_GIE_BIT = 1;
    localparam logic CTRL_RUN_RST = 1'b1;
    localparam logic CTRL_GIE_RST = 1'b0;
    // status register fields
    localparam int STAT_PC_LSB = 0;
    localparam int STAT_ACC_LSB = 16;
    localparam int STAT_C_BIT = 24;
    localparam int STAT_Z_BIT = 25;
    localparam int STAT_AC_BIT = 26;
    localparam int STAT_PEND_BIT = 27;
    localparam int STAT_DUMMY_BIT = 28;
    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [15:0] INSTR_NOP = 16'h0000;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // instruction word layout
    localparam int CLS_MSB = 15;
    localparam int CLS_LSB = 12;
    localparam int ALUOP_MSB = 11;
    localparam int ALUOP_LSB = 8;
    localparam int SKC_MSB = 9;
    localparam int SKC_LSB = 8;
    // phases per instruction cycle and counter bits per page
    localparam int PHASES = 4;
    localparam int PAGE_BITS = 8;
    // instruction classes
    localparam logic [3:0] CLS_NOP = 4'h0;
    localparam logic [3:0] CLS_ALU = 4'h1;
    localparam logic [3:0] CLS_JMP = 4'h2;
    localparam logic [3:0] CLS_CALL = 4'h3;
    localparam logic [3:0] CLS_SUBRET = 4'h4;
    localparam logic [3:0] CLS_INTRET = 4'h5;
    localparam logic [3:0] CLS_SKIP = 4'h6;
    localparam logic [3:0] CLS_LOB_WR = 4'h7;
    localparam logic [3:0] CLS_LOB_RD = 4'h8;
    // skip conditions
    localparam logic [1:0] SK_ZERO = 2'd0;
    localparam logic [1:0] SK_NZERO = 2'd1;
    localparam logic [1:0] SK_INC_Z = 2'd2;
    localparam logic [1:0] SK_DEC_Z = 2'd3;
    // alu operations
    localparam logic [3:0] ALU_ADD = 4'd0;
    localparam logic [3:0] ALU_ADC = 4'd1;
    localparam logic [3:0] ALU_SUB = 4'd2;
    localparam logic [3:0] ALU_SBC = 4'd3;
    localparam logic [3:0] ALU_DAA = 4'd4;
    localparam logic [3:0] ALU_AND = 4'd5;
    localparam logic [3:0] ALU_OR = 4'd6;
    localparam logic [3:0] ALU_XOR = 4'd7;
    localparam logic [3:0] ALU_CPL = 4'd8;
    localparam logic [3:0] ALU_RR = 4'd9;
    localparam logic [3:0] ALU_RRC = 4'd10;
    localparam logic [3:0] ALU_RL = 4'd11;
    localparam logic [3:0] ALU_RLC = 4'd12;
    localparam logic [3:0] ALU_INC = 4'd13;
    localparam logic [3:0] ALU_DEC = 4'd14;
    localparam logic [3:0] ALU_MOV = 4'd15;
    // phase names, fetch phase first
    typedef enum logic [1:0] {PH_FETCH, PH_DECODE, PH_EXEC, PH_WRITE} phase_t;
    // register selector
    typedef enum logic [2:0] {SEL_CTRL, SEL_LOB, SEL_STATUS, SEL_INSTR, SEL_NONE} reg_sel_t;
endpackage
`default_nettype wire
